/* File: src/tap_pkg.sv */
// Package: constants and types shared by the boundary-scan instruction logic
package tap_pkg;

  // Instruction register geometry and codes
  localparam int unsigned IR_LEN       = 8;
  localparam logic [7:0]  OP_EXTEST    = 8'h00;
  localparam logic [7:0]  OP_IDCODE    = 8'h21;
  localparam logic [7:0]  OP_SAMPLE    = 8'h05;
  localparam logic [7:0]  OP_CLAMP     = 8'h07;
  localparam logic [7:0]  OP_HIGHZ     = 8'h03;
  localparam logic [7:0]  OP_BYPASS    = 8'hff;
  // Value loaded into the instruction shifter in Capture-IR (low bits 01)
  localparam logic [7:0]  IR_CAPTURE   = 8'h01;

  // Data register geometry
  localparam int unsigned ID_LEN       = 32;
  localparam int unsigned N_IN         = 8;   // Sampled input balls
  localparam int unsigned N_OUT        = 8;   // Driven output balls
  localparam int unsigned BSR_LEN      = N_IN + N_OUT;
  // Bypass cell always captures zero
  localparam logic        BYPASS_CAPTURE = 1'b0;

  // Synchroniser depth for pins from the test clock domain
  localparam int unsigned SYNC_STAGES  = 2;

  // Which data register sits between serial in and out
  typedef enum {
    SEL_ID,
    SEL_BSR,
    SEL_BYP
  } dr_sel_t;

  // Test access port controller states
  typedef enum {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_t;

endpackage : tap_pkg

/* File: src/tap_if.sv */
// Interface: test clock rising-edge strobe, mode select and controller state flags
`timescale 1ns/1ns
`default_nettype none
interface tap_if;
  logic tck_rise;  // One-cycle strobe at a test clock rising edge
  logic tms;       // Synchronised mode select
  logic in_tlr;    // Controller in Test-Logic-Reset
  logic in_cap_dr; // Controller in Capture-DR
  logic in_sh_dr;  // Controller in Shift-DR
  logic in_upd_dr; // Controller in Update-DR
  logic in_cap_ir; // Controller in Capture-IR
  logic in_sh_ir;  // Controller in Shift-IR
  logic in_upd_ir; // Controller in Update-IR

  // Controller side drives the state flags
  modport fsm (
    input  tck_rise, tms,
    output in_tlr, in_cap_dr, in_sh_dr, in_upd_dr, in_cap_ir, in_sh_ir, in_upd_ir
  );
  // Instruction and register side reads them
  modport core (
    output tck_rise, tms,
    input  in_tlr, in_cap_dr, in_sh_dr, in_upd_dr, in_cap_ir, in_sh_ir, in_upd_ir
  );
endinterface : tap_if
`default_nettype wire

/* File: src/tap_fsm.sv */
// Module: sixteen-state test access port controller stepped by test clock edges
`timescale 1ns/1ns
`default_nettype none
module tap_fsm
  import tap_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  tap_if.fsm        tap
);

  tap_state_t state_q;  // Present controller state
  tap_state_t state_d;  // State after the next test clock edge

  // Standard transition table, selected by the mode select level
  function automatic tap_state_t next_state(input tap_state_t s, input logic m);
    case (s)
      ST_RESET:  next_state = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = m ? ST_SEL_DR : ST_IDLE;
      default:   next_state = ST_RESET;
    endcase
  endfunction : next_state

  // Advance only on a test clock rising edge
  assign state_d = tap.tck_rise ? next_state(state_q, tap.tms) : state_q;

  // State register; system reset stands in for power-up
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // State flags for the instruction and register logic
  assign tap.in_tlr    = (state_q == ST_RESET);
  assign tap.in_cap_dr = (state_q == ST_CAP_DR);
  assign tap.in_sh_dr  = (state_q == ST_SH_DR);
  assign tap.in_upd_dr = (state_q == ST_UPD_DR);
  assign tap.in_cap_ir = (state_q == ST_CAP_IR);
  assign tap.in_sh_ir  = (state_q == ST_SH_IR);
  assign tap.in_upd_ir = (state_q == ST_UPD_IR);

endmodule : tap_fsm
`default_nettype wire

/* File: src/scan_port.sv */
// Module: boundary-scan instruction decode, data registers and output ball control
`timescale 1ns/1ns
`default_nettype none
module scan_port
  import tap_pkg::*;
#(
  parameter logic [ID_LEN-1:0] ID_VALUE = 32'h0000_0001  // Arbitrary identity, LSB set
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             tck_in,
  input  wire logic             tms_in,
  input  wire logic             tdi_in,
  input  wire logic [N_IN-1:0]  ball_in,
  input  wire logic [N_OUT-1:0] func_data_in,
  input  wire logic [N_OUT-1:0] func_oe_in,
  output logic                  tdo_out,
  output logic                  tdo_oe_out,
  output logic [N_OUT-1:0]      ball_out,
  output logic [N_OUT-1:0]      ball_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the test pins and the sampled balls

  logic [SYNC_STAGES-1:0] tck_sync_q;  // Test clock, two stages
  logic                   tck_last_q;  // Delayed copy for edge finding
  logic [SYNC_STAGES-1:0] tms_sync_q;  // Mode select, two stages
  logic [SYNC_STAGES-1:0] tdi_sync_q;  // Serial data in, two stages
  logic [N_IN-1:0]        ball_s1_q;   // Input balls, first stage
  logic [N_IN-1:0]        ball_s2_q;   // Input balls, second stage

  // Only the second stage feeds any logic; sampled balls may be caught mid-flip
  always_ff @(posedge clock_in) begin
    tck_sync_q <= {tck_sync_q[0], tck_in};
    tms_sync_q <= {tms_sync_q[0], tms_in};
    tdi_sync_q <= {tdi_sync_q[0], tdi_in};
    ball_s1_q  <= ball_in;
    ball_s2_q  <= ball_s1_q;
    tck_last_q <= tck_sync_q[1];
  end

  wire tck_rise = tck_sync_q[1] & ~tck_last_q;  // Shift and capture edge
  wire tck_fall = ~tck_sync_q[1] & tck_last_q;  // Serial out launch edge
  wire tdi      = tdi_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Controller

  tap_if tap ();
  assign tap.tck_rise = tck_rise;
  assign tap.tms      = tms_sync_q[1];

  tap_fsm u_fsm (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .tap      (tap)
  );

  // Register actions happen at the rising edge that leaves the state
  wire do_cap_ir = tck_rise & tap.in_cap_ir;
  wire do_sh_ir  = tck_rise & tap.in_sh_ir;
  wire do_cap_dr = tck_rise & tap.in_cap_dr;
  wire do_sh_dr  = tck_rise & tap.in_sh_dr;
  wire do_upd_dr = tck_rise & tap.in_upd_dr;
  wire do_upd_ir = tck_rise & tap.in_upd_ir;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register and decode

  logic [IR_LEN-1:0] ir_sh_q;  // Instruction shifter
  logic [IR_LEN-1:0] ir_q;     // Current instruction

  // Shift in Shift-IR, take effect only at Update-IR
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (do_cap_ir) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (do_sh_ir) begin
      ir_sh_q <= {tdi, ir_sh_q[IR_LEN-1:1]};
    end
  end

  // Reset and Test-Logic-Reset restore the identification code
  always_ff @(posedge clock_in) begin
    if (rst_in || tap.in_tlr) begin
      ir_q <= OP_IDCODE;
    end else if (do_upd_ir) begin
      ir_q <= ir_sh_q;
    end
  end

  // Data register selection per instruction
  function automatic dr_sel_t dr_select(input logic [IR_LEN-1:0] op);
    case (op)
      OP_IDCODE: dr_select = SEL_ID;
      OP_SAMPLE: dr_select = SEL_BSR;
      OP_EXTEST: dr_select = SEL_BSR;
      OP_CLAMP:  dr_select = SEL_BYP;
      OP_HIGHZ:  dr_select = SEL_BYP;
      OP_BYPASS: dr_select = SEL_BYP;
      // Reserved codes fall back to bypass so the chain stays short
      default:   dr_select = SEL_BYP;
    endcase
  endfunction : dr_select

  // A variable, not a net: the selection enum has a two-state base type
  dr_sel_t      sel;
  assign sel = dr_select(ir_q);
  wire          op_bsr   = (ir_q == OP_SAMPLE) || (ir_q == OP_EXTEST);
  wire          op_force = (ir_q == OP_CLAMP) || (ir_q == OP_EXTEST);
  wire          op_highz = (ir_q == OP_HIGHZ);

  ////////////////////////////////////////////////////////////////////////////
  // Data registers

  logic [ID_LEN-1:0]  id_sh_q;   // Identification shifter
  logic [BSR_LEN-1:0] bsr_sh_q;  // Boundary shifter: outputs high, inputs low
  logic [N_OUT-1:0]   bsr_upd_q; // Output cell hold latches
  logic               byp_q;     // Single bypass stage

  // Identification register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      id_sh_q <= ID_VALUE;
    end else if (do_cap_dr && sel == SEL_ID) begin
      id_sh_q <= ID_VALUE;
    end else if (do_sh_dr && sel == SEL_ID) begin
      id_sh_q <= {tdi, id_sh_q[ID_LEN-1:1]};
    end
  end

  // Boundary shifter; captures the balls as they stand
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bsr_sh_q <= '0;
    end else if (do_cap_dr && op_bsr) begin
      bsr_sh_q <= {ball_out, ball_s2_q};
    end else if (do_sh_dr && sel == SEL_BSR) begin
      bsr_sh_q <= {tdi, bsr_sh_q[BSR_LEN-1:1]};
    end
  end

  // Output cells update only under sample/preload or external test
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bsr_upd_q <= '0;
    end else if (do_upd_dr && op_bsr) begin
      bsr_upd_q <= bsr_sh_q[BSR_LEN-1:N_IN];
    end
  end

  // Bypass stage
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      byp_q <= BYPASS_CAPTURE;
    end else if (do_cap_dr) begin
      byp_q <= BYPASS_CAPTURE;
    end else if (do_sh_dr && sel == SEL_BYP) begin
      byp_q <= tdi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial out, launched on the falling test clock edge

  wire dr_lsb = (sel == SEL_ID)  ? id_sh_q[0] :
                (sel == SEL_BSR) ? bsr_sh_q[0] : byp_q;
  wire shifting = tap.in_sh_ir | tap.in_sh_dr;
  // Serial out parks low outside the shift states, so a disabled pin reads zero
  wire tdo_d    = shifting & (tap.in_sh_ir ? ir_sh_q[0] : dr_lsb);

  // Driver enabled only while a shift state is held
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out    <= tdo_d;
      tdo_oe_out <= shifting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output ball control

  // High-impedance wins, then held cells, then functional data
  wire [N_OUT-1:0] ball_d    = op_force ? bsr_upd_q : func_data_in;
  wire [N_OUT-1:0] ball_oe_d = op_highz ? '0 :
                               op_force ? '1 : func_oe_in;

  // Registered so the balls come straight from flip-flops
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ball_out    <= '0;
      ball_oe_out <= '0;
    end else begin
      ball_out    <= ball_d;
      ball_oe_out <= ball_oe_d;
    end
  end

endmodule : scan_port
`default_nettype wire

/* File: test/scan_port_chk.sv */
// Checker: port-level timing and output-mode properties of the scan port
`timescale 1ns/1ns
`default_nettype none
module scan_port_chk
  import tap_pkg::*;
(
  input wire logic             clock_in,
  input wire logic             rst_in,
  input wire logic             tck_in,
  input wire logic [N_OUT-1:0] func_data_in,
  input wire logic [N_OUT-1:0] func_oe_in,
  input wire logic             tdo_out,
  input wire logic             tdo_oe_out,
  input wire logic [N_OUT-1:0] ball_out,
  input wire logic [N_OUT-1:0] ball_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  // A shift or idle stretch spans at least one test clock period
  sequence s_oe_high8;
    tdo_oe_out [*8];
  endsequence
  sequence s_oe_low8;
    !tdo_oe_out [*8];
  endsequence
  a_rst_quiet:
    assert property ($fell(rst_in) |-> !tdo_out && !tdo_oe_out && ball_oe_out == '0)
    else $error("outputs not quiet after reset");
  a_tdo_after_fall:
    assert property ($changed(tdo_out) |-> !$past(tck_in, 3))
    else $error("serial out moved with test clock high");
  a_oe_after_fall:
    assert property ($changed(tdo_oe_out) |-> !$past(tck_in, 3))
    else $error("serial enable moved with test clock high");
  a_oe_min_high:
    assert property ($rose(tdo_oe_out) |-> s_oe_high8)
    else $error("serial enable pulse too short");
  a_oe_min_low:
    assert property ($fell(tdo_oe_out) |-> s_oe_low8)
    else $error("serial enable gap too short");
  a_tdo_idle_zero:
    assert property (!tdo_oe_out |-> !tdo_out)
    else $error("serial out high while disabled");
  a_ball_oe_mode:
    assert property (ball_oe_out == '0 || ball_oe_out == '1 ||
                     ball_oe_out == $past(func_oe_in))
    else $error("ball enable neither functional nor forced");
  a_ball_data_mode:
    assert property (ball_oe_out != $past(func_oe_in) || ball_out == $past(func_data_in))
    else $error("functional data not passed to balls");
endmodule : scan_port_chk
bind scan_port scan_port_chk i_scan_port_chk (.clock_in(clock_in), .rst_in(rst_in),
  .tck_in(tck_in), .func_data_in(func_data_in), .func_oe_in(func_oe_in),
  .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .ball_out(ball_out), .ball_oe_out(ball_oe_out));
`default_nettype wire

/* File: test/tap_driver.sv */
// Partner model: external boundary-scan controller stepping the test port
`timescale 1ns/1ns
`default_nettype none
module tap_driver (
  input  wire logic clock_in,
  input  wire logic tdo_in,
  output var  logic tck_out,
  output var  logic tms_out,
  output var  logic tdi_out
);
  // Test clock stands low until the first frame
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  ////////////////////////////////////////
  // One 64 ns test clock: 4 cycles low, 4 high; serial out taken mid high half
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(posedge clock_in);
    tck_out <= 1'b0;
    tms_out <= tms;
    tdi_out <= tdi;
    repeat (4) @(posedge clock_in);
    tck_out <= 1'b1;
    repeat (2) @(posedge clock_in);
    tdo = tdo_in;
    @(posedge clock_in);
  endtask : tick
  // Five mode-high clocks reach Test-Logic-Reset, then park in idle
  task automatic to_reset();
    logic b;
    repeat (5) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask : to_reset
  // Walk idle to a shift state, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b0, b);
    if (ir) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask : scan
endmodule : tap_driver
`default_nettype wire

/* File: test/memory_jtag_instruction_decode_test.sv */
// Testbench: instruction loads and scans through the scan port
`timescale 1ns/1ns
`default_nettype none
module memory_jtag_instruction_decode_test
  import tap_pkg::*;
;
  localparam logic [31:0] ID = 32'h8a5c_3e71;  // Arbitrary identity, LSB set
  logic             clock_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             tck, tms, tdi, tdo, tdo_oe;
  logic [N_OUT-1:0] func_data_in = 8'h3c;
  logic [N_OUT-1:0] func_oe_in = 8'ha5;
  logic [N_IN-1:0]  ball_in = 8'h96;
  logic [N_OUT-1:0] ball_out, ball_oe_out;
  logic [31:0]      d;
  int               num_errors = 0;
  int               checks_done = 0;
  always #4 clock_in = ~clock_in;
  scan_port #(.ID_VALUE(ID)) i_scan_port (.clock_in(clock_in), .rst_in(rst_in),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .ball_in(ball_in), .func_data_in(func_data_in),
    .func_oe_in(func_oe_in), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .ball_out(ball_out),
    .ball_oe_out(ball_oe_out));
  tap_driver i_tap_driver (.clock_in(clock_in), .tdo_in(tdo), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi));
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // Ball outputs follow a new instruction one system clock after Update-IR acts
  task automatic settle();
    repeat (2) @(posedge clock_in);
  endtask : settle
  // Identity value sits in the data path with no instruction loaded
  task automatic t_idcode();
    i_tap_driver.scan(1'b0, 32, 32'h0, d);
    chk("idcode", ID, d);
  endtask : t_idcode
  // Sample captures balls and functional outputs; preload fills output cells
  task automatic t_sample();
    i_tap_driver.scan(1'b1, 8, 32'h05, d);
    chk("ir capture", 32'h01, d);
    i_tap_driver.scan(1'b0, 16, 32'hc300, d);
    chk("sample", 32'h3c96, d);
  endtask : t_sample
  // Clamp, high-impedance and bypass: ball control and one-stage path
  task automatic t_modes();
    logic [7:0] op [3] = '{OP_CLAMP, OP_HIGHZ, OP_BYPASS};
    logic [7:0] oe [3] = '{8'hff, 8'h00, 8'ha5};
    for (int k = 0; k < 3; k++) begin
      i_tap_driver.scan(1'b1, 8, {24'h0, op[k]}, d);
      settle();
      chk("mode oe", {24'h0, oe[k]}, {24'h0, ball_oe_out});
      if (k == 0) chk("clamp out", 32'hc3, {24'h0, ball_out});
      i_tap_driver.scan(1'b0, 4, 32'hb, d);
      chk("one stage", 32'h6, d);
    end
  endtask : t_modes
  // External test drives preloaded cells, captures inputs; reset restores identity
  task automatic t_extest();
    i_tap_driver.scan(1'b1, 8, 32'h00, d);
    settle();
    chk("extest out", 32'hffc3, {16'h0, ball_oe_out, ball_out});
    i_tap_driver.scan(1'b0, 16, 32'hc300, d);
    chk("extest in", 32'h96, {24'h0, d[7:0]});
    i_tap_driver.to_reset();
    t_idcode();
  endtask : t_extest
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    i_tap_driver.to_reset();
    t_idcode();
    t_sample();
    t_modes();
    t_extest();
    end_of_test();
  end
  // Watchdog: all scans need well under 20000 cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    end_of_test();
  end
endmodule : memory_jtag_instruction_decode_test
`default_nettype wire
